// ---- logic/pdcc_defs.vh ----
// Purpose: constants for the power-down clock control block
// Assumes: 32-bit register port, clk_sys at 250 MHz
// Notes:   offsets are byte addresses on the register port
`ifndef PDCC_DEFS_VH
`define PDCC_DEFS_VH

`define PDCC_ADDR_W            4
`define PDCC_DATA_W            32
`define PDCC_CLK_PERIOD_NS     4

// register offsets
`define PDCC_OFS_PDN_CTRL      4'h0
`define PDCC_OFS_CLK_GATE      4'h4
`define PDCC_OFS_STATUS        4'h8

// power_down_control fields
`define PDCC_BIT_CORE_STOP     0
`define PDCC_BIT_CHIP_PDN      1
`define PDCC_BIT_WAKE_EXT      2
`define PDCC_BIT_WAKE_RTC      3
`define PDCC_BIT_HALT_SEL      4
`define PDCC_PDN_RESET         5'h10

// clock_gate_control fields
`define PDCC_NUM_MOD           8
`define PDCC_GATE_LSB          0
`define PDCC_RST_LSB           8
`define PDCC_GATE_RESET        8'hFF
`define PDCC_MRST_RESET        8'h00

// status fields
`define PDCC_ST_HALT           0
`define PDCC_ST_DOZE           1
`define PDCC_ST_CORE_OFF       2
`define PDCC_ST_PDN_ACT        3
`define PDCC_ST_PLL_LOCK       4

// timing
`define PDCC_STOP_DELAY_NS     100
`define PDCC_PLL_SETTLE_NS     100000

`endif

// ---- logic/pdcc_power_down_clock_control.v ----
// Purpose: core halt/doze, core clock stop, peripheral clock gating
//          and chip power-down with PLL stop and wake-up
// Assumes: this logic runs on an always-on clock; gating cells outside
//          take the registered enables on a low clock phase
// Notes:   module order in gate/reset fields: DMA, PCI, CHI, serial,
//          timers, SPI, parallel I/O, AC-link (bit 0 upward)
//
// Contract
// - wait instruction puts core into halt or doze
// - interrupt exception takes the core out of halt or doze
// - halt-select bit picks halt or doze; halt recommended
// - core-clock-stop set then wait stops the core clock
// - core-clock-stop stays set after wake; software clears it
// - independent clock on/off for each of eight peripheral modules
// - module reset bit returns that module's registers to reset values
// - writing 1 to chip-power-down stops generator clocks and PLL; code starts this only when the stored bit was 0
// - during power-down only the real-time clock keeps running
// - wake from power-down on selected external or RTC interrupt
// - power-down with interrupts disabled recovers only by reset
// - chip-power-down stays set after wake; software clears it
`timescale 1ns/10ps
`include "pdcc_defs.vh"

module pdcc_power_down_clock_control
#(
	parameter PLL_SETTLE_CYCLES = (`PDCC_PLL_SETTLE_NS +
		`PDCC_CLK_PERIOD_NS - 1) / `PDCC_CLK_PERIOD_NS,
	parameter CNT_W             = 16
)
(
	input  wire                        clk_sys,
	input  wire                        rst,
	input  wire                        clk_en,
	input  wire [`PDCC_ADDR_W-1:0]     reg_addr,
	input  wire [`PDCC_DATA_W-1:0]     reg_wdata,
	input  wire                        reg_wr,
	input  wire                        reg_rd,
	output reg  [`PDCC_DATA_W-1:0]     reg_rdata_q,
	input  wire                        wait_exec,
	input  wire                        core_irq,
	input  wire                        int_any_enabled,
	input  wire                        ext_irq,
	input  wire                        rtc_irq,
	input  wire                        pll_lock,
	output reg                         core_halt_q,
	output reg                         core_doze_q,
	output reg                         core_clk_en_q,
	output reg  [`PDCC_NUM_MOD-1:0]    periph_clk_en_q,
	output reg  [`PDCC_NUM_MOD-1:0]    periph_rst_q,
	output reg                         gen_clk_en_q,
	output reg                         pll_stop_q,
	output reg                         rtc_clk_en_q
);

	// delays rounded up to whole cycles, never below one
	localparam STOP_CYCLES_RAW = (`PDCC_STOP_DELAY_NS +
		`PDCC_CLK_PERIOD_NS - 1) / `PDCC_CLK_PERIOD_NS;
	localparam STOP_CYCLES = (STOP_CYCLES_RAW < 1) ? 1 : STOP_CYCLES_RAW;
	localparam SETTLE_CYC  = (PLL_SETTLE_CYCLES < 1) ? 1 :
		PLL_SETTLE_CYCLES;
	localparam [31:0]      STOP_LAST_W   = STOP_CYCLES - 1;
	localparam [31:0]      SETTLE_LAST_W = SETTLE_CYC - 1;
	localparam [CNT_W-1:0] STOP_LAST     = STOP_LAST_W[CNT_W-1:0];
	localparam [CNT_W-1:0] SETTLE_LAST   = SETTLE_LAST_W[CNT_W-1:0];

	// power-down sequencer, one-hot
	localparam [3:0] ST_RUN    = 4'h1;
	localparam [3:0] ST_STOP   = 4'h2;
	localparam [3:0] ST_DOWN   = 4'h4;
	localparam [3:0] ST_RELOCK = 4'h8;

	reg  [4:0]               pdn_ctrl_q;
	reg  [`PDCC_NUM_MOD-1:0] gate_q;
	reg  [`PDCC_NUM_MOD-1:0] mrst_q;
	reg  [3:0]               state_q;
	reg  [3:0]               state_d;
	reg  [CNT_W-1:0]         cnt_q;
	reg  [CNT_W-1:0]         cnt_d;
	reg  [1:0]               ext_sync_q;
	reg  [1:0]               rtc_sync_q;
	reg  [1:0]               lock_sync_q;
	reg  [1:0]               inten_sync_q;
	reg                      gen_run_d;
	reg                      pll_stop_d;
	reg  [`PDCC_DATA_W-1:0]  rdata_d;

	wire wr_pdn    = reg_wr && (reg_addr == `PDCC_OFS_PDN_CTRL);
	wire wr_gate   = reg_wr && (reg_addr == `PDCC_OFS_CLK_GATE);
	// only a 0 to 1 change of the stored bit starts a power-down
	wire pdn_start = wr_pdn && reg_wdata[`PDCC_BIT_CHIP_PDN] &&
		!pdn_ctrl_q[`PDCC_BIT_CHIP_PDN];
	wire wake_ext  = pdn_ctrl_q[`PDCC_BIT_WAKE_EXT] && ext_sync_q[1];
	wire wake_rtc  = pdn_ctrl_q[`PDCC_BIT_WAKE_RTC] && rtc_sync_q[1];
	// no enabled interrupt: only reset leaves power-down
	wire wake      = inten_sync_q[1] && (wake_ext || wake_rtc);
	wire core_low  = core_halt_q || core_doze_q;

	// pin and foreign-domain inputs, two flops each
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ext_sync_q   <= 2'h0;
			rtc_sync_q   <= 2'h0;
			lock_sync_q  <= 2'h0;
			inten_sync_q <= 2'h0;
		end
		else if (clk_en)
		begin
			ext_sync_q   <= {ext_sync_q[0], ext_irq};
			rtc_sync_q   <= {rtc_sync_q[0], rtc_irq};
			lock_sync_q  <= {lock_sync_q[0], pll_lock};
			inten_sync_q <= {inten_sync_q[0], int_any_enabled};
		end
	end

	// control registers; no bit is cleared by hardware
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pdn_ctrl_q <= `PDCC_PDN_RESET;
			gate_q     <= `PDCC_GATE_RESET;
			mrst_q     <= `PDCC_MRST_RESET;
		end
		else if (clk_en)
		begin
			if (wr_pdn)
				pdn_ctrl_q <= reg_wdata[4:0];
			if (wr_gate)
			begin
				gate_q <= reg_wdata[`PDCC_GATE_LSB +: `PDCC_NUM_MOD];
				mrst_q <= reg_wdata[`PDCC_RST_LSB +: `PDCC_NUM_MOD];
			end
		end
	end

	// read data stands for the one cycle after the strobe
	always @*
	begin
		rdata_d = {`PDCC_DATA_W{1'b0}};
		if (reg_rd)
		begin
			case (reg_addr)
				`PDCC_OFS_PDN_CTRL:
					rdata_d[4:0] = pdn_ctrl_q;
				`PDCC_OFS_CLK_GATE:
				begin
					rdata_d[`PDCC_GATE_LSB +: `PDCC_NUM_MOD] = gate_q;
					rdata_d[`PDCC_RST_LSB +: `PDCC_NUM_MOD]  = mrst_q;
				end
				// status shows live state, nothing latched
				`PDCC_OFS_STATUS:
				begin
					rdata_d[`PDCC_ST_HALT]     = core_halt_q;
					rdata_d[`PDCC_ST_DOZE]     = core_doze_q;
					rdata_d[`PDCC_ST_CORE_OFF] = !core_clk_en_q;
					rdata_d[`PDCC_ST_PDN_ACT]  = !state_q[0];
					rdata_d[`PDCC_ST_PLL_LOCK] = lock_sync_q[1];
				end
				default:
					rdata_d = {`PDCC_DATA_W{1'b0}};
			endcase
		end
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			reg_rdata_q <= {`PDCC_DATA_W{1'b0}};
		else if (clk_en)
			reg_rdata_q <= rdata_d;
	end

	// core low-power states and core clock gate
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			core_halt_q   <= 1'b0;
			core_doze_q   <= 1'b0;
			core_clk_en_q <= 1'b1;
		end
		else if (clk_en)
		begin
			if (core_low && core_irq)
			begin
				core_halt_q   <= 1'b0;
				core_doze_q   <= 1'b0;
				core_clk_en_q <= gen_run_d;
			end
			else if (wait_exec && !core_low)
			begin
				core_halt_q   <= pdn_ctrl_q[`PDCC_BIT_HALT_SEL];
				core_doze_q   <= !pdn_ctrl_q[`PDCC_BIT_HALT_SEL];
				core_clk_en_q <= gen_run_d &&
					!pdn_ctrl_q[`PDCC_BIT_CORE_STOP];
			end
			// a stopped core clock waits for the interrupt
			else if (!(core_low && pdn_ctrl_q[`PDCC_BIT_CORE_STOP]))
				core_clk_en_q <= gen_run_d;
		end
	end

	// power-down sequencer
	always @*
	begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		gen_run_d  = gen_clk_en_q;
		pll_stop_d = pll_stop_q;
		case (state_q)
			ST_RUN:
				if (pdn_start)
				begin
					state_d   = ST_STOP;
					gen_run_d = 1'b0;
					cnt_d     = {CNT_W{1'b0}};
				end
			ST_STOP:
				// generator off first, PLL after the stop delay
				if (cnt_q == STOP_LAST)
				begin
					state_d    = ST_DOWN;
					pll_stop_d = 1'b1;
				end
				else
					cnt_d = cnt_q + 1'b1;
			ST_DOWN:
				if (wake)
				begin
					state_d    = ST_RELOCK;
					pll_stop_d = 1'b0;
					cnt_d      = {CNT_W{1'b0}};
				end
			ST_RELOCK:
				// settle time first, then synced lock
				if (cnt_q != SETTLE_LAST)
					cnt_d = cnt_q + 1'b1;
				else if (lock_sync_q[1])
				begin
					state_d   = ST_RUN;
					gen_run_d = 1'b1;
				end
			default:
			begin
				state_d    = ST_RUN;
				gen_run_d  = 1'b1;
				pll_stop_d = 1'b0;
			end
		endcase
	end

	// rtc clock runs from the first edge, power-down included
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q      <= ST_RUN;
			cnt_q        <= {CNT_W{1'b0}};
			gen_clk_en_q <= 1'b1;
			pll_stop_q   <= 1'b0;
			rtc_clk_en_q <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			gen_clk_en_q <= gen_run_d;
			pll_stop_q   <= pll_stop_d;
			rtc_clk_en_q <= 1'b1;
		end
	end

	// per-module clock enable and reset
	// module clocks drop with the generator
	genvar gi;
	generate
		for (gi = 0; gi < `PDCC_NUM_MOD; gi = gi + 1)
		begin : g_mod
			always @(posedge clk_sys or posedge rst)
			begin
				if (rst)
				begin
					periph_clk_en_q[gi] <= 1'b0;
					periph_rst_q[gi]    <= 1'b1;
				end
				else if (clk_en)
				begin
					periph_clk_en_q[gi] <= gate_q[gi] && gen_run_d;
					periph_rst_q[gi]    <= mrst_q[gi];
				end
			end
		end
	endgenerate

endmodule

// ---- testbench/pdcc_sva.sv ----
// Purpose: port assertions for the power-down clock control block
// Assumes: clk_en held high, settle count of 8
// Notes:   bound into every instance of the block
`timescale 1ns/10ps
module pdcc_sva
(
	input wire       clk_sys,
	input wire       rst,
	input wire       wait_exec,
	input wire       core_irq,
	input wire       pll_lock,
	input wire       core_halt_q,
	input wire       core_doze_q,
	input wire       core_clk_en_q,
	input wire [7:0] periph_clk_en_q,
	input wire       gen_clk_en_q,
	input wire       pll_stop_q,
	input wire       rtc_clk_en_q
);
	wire lp = core_halt_q | core_doze_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_wait_enter: assert property (wait_exec && !lp && !core_irq
		|=> core_halt_q ^ core_doze_q)
		else $error("wait ignored");
	a_lp_holds: assert property (lp && !core_irq |=> lp)
		else $error("low power left early");
	a_irq_exit: assert property (lp && core_irq |=> !lp)
		else $error("interrupt did not wake core");
	a_stop_cause: assert property ($fell(core_clk_en_q)
		|-> lp || !gen_clk_en_q)
		else $error("core clock stopped unasked");
	a_pdn_all_off: assert property ($fell(gen_clk_en_q)
		|-> !core_clk_en_q && periph_clk_en_q == 8'h00)
		else $error("clock left on in power-down");
	a_pll_delay: assert property ($fell(gen_clk_en_q)
		|-> ##25 $rose(pll_stop_q))
		else $error("pll stop delay wrong");
	a_rtc_alive: assert property (pll_stop_q |-> rtc_clk_en_q)
		else $error("rtc clock stopped");
	a_pll_settle: assert property ($fell(pll_stop_q)
		|-> !gen_clk_en_q [*8])
		else $error("clocks before pll settled");
	a_gen_lock: assert property ($rose(gen_clk_en_q)
		|-> !pll_stop_q && !$past(pll_stop_q, 8))
		else $error("clocks before pll restart");
	c_halt: cover property ($rose(core_halt_q));
	c_pdn: cover property ($rose(pll_stop_q));
	c_wake: cover property ($rose(gen_clk_en_q));
endmodule
bind pdcc_power_down_clock_control pdcc_sva u_sva
(
	.clk_sys, .rst, .wait_exec, .core_irq, .pll_lock, .core_halt_q,
	.core_doze_q, .core_clk_en_q, .periph_clk_en_q, .gen_clk_en_q,
	.pll_stop_q, .rtc_clk_en_q
);

// ---- testbench/testbench.sv ----
// Purpose: directed bench for the power-down clock control block
// Assumes: clk_en high but for one freeze check, settle count cut to 8
// Notes:   registers reached by one-cycle strobes
`timescale 1ns/10ps
module testbench;
	logic        clk_sys = 1'h0, rst = 1'h1, clk_en = 1'h1;
	logic        reg_wr = 1'h0, reg_rd = 1'h0, wait_exec = 1'h0;
	logic        core_irq = 1'h0, int_any_enabled = 1'h1, pll_lock = 1'h1;
	logic        ext_irq = 1'h0, rtc_irq = 1'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, ctl;
	wire  [31:0] reg_rdata_q;
	wire  [7:0]  periph_clk_en_q, periph_rst_q;
	wire         core_halt_q, core_doze_q, core_clk_en_q, gen_clk_en_q;
	wire         pll_stop_q, rtc_clk_en_q;
	int          bad_count = 0, num_checks = 0, n, i;
	pdcc_power_down_clock_control #(.PLL_SETTLE_CYCLES(8)) u_dut
	(
		.clk_sys, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_q, .wait_exec, .core_irq, .int_any_enabled, .ext_irq,
		.rtc_irq, .pll_lock, .core_halt_q, .core_doze_q, .core_clk_en_q,
		.periph_clk_en_q, .periph_rst_q, .gen_clk_en_q, .pll_stop_q,
		.rtc_clk_en_q
	);
	always #2 clk_sys = ~clk_sys;
	task wrap_up;
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task tmo(input int k);
		if (k >= 200)
		begin
			bad_count++;
			wrap_up;
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata_q, e);
	endtask
	task pulse(input logic irq);
		@(posedge clk_sys);
		{core_irq, wait_exec} <= irq ? 2'h2 : 2'h1;
		@(posedge clk_sys);
		{core_irq, wait_exec} <= 2'h0;
		#1;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		wrap_up;
	end
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'h0;
		cyc(2);
		chk({periph_clk_en_q, rtc_clk_en_q}, 32'h1FF);
		rd(4'h0, 32'h10);
		rd(4'h4, 32'hFF);
		rd(4'h8, 32'h10);
		rd(4'hC, 32'h0);
		clk_en <= 1'h0;
		wr(4'h4, 32'h0);
		clk_en <= 1'h1;
		rd(4'h4, 32'hFF);
		ctl = 32'hFF;
		for (i = 0; i < 8; i++)
		begin
			wr(4'h4, 32'hFF00 | ctl);
			cyc(2);
			chk({periph_rst_q, periph_clk_en_q}, 32'hFF00 | ctl);
			wr(4'h4, 32'hFF00 | (32'h1 << i));
			wr(4'h4, 32'h1 << i);
			cyc(2);
			chk({periph_rst_q, periph_clk_en_q}, 32'h1 << i);
			ctl = 32'h1 << i;
		end
		wr(4'h0, 32'h11);
		pulse(1'h0);
		chk({core_halt_q, core_doze_q, core_clk_en_q}, 32'h4);
		rd(4'h8, 32'h15);
		pulse(1'h0);
		chk(core_halt_q, 32'h1);
		pulse(1'h1);
		cyc(1);
		chk({core_halt_q, core_doze_q, core_clk_en_q}, 32'h1);
		rd(4'h0, 32'h11);
		wr(4'h0, 32'h0);
		pulse(1'h0);
		chk({core_halt_q, core_doze_q, core_clk_en_q}, 32'h3);
		rd(4'h8, 32'h12);
		pulse(1'h1);
		for (i = 0; i < 3; i++)
		begin
			ctl = i == 1 ? 32'h8 : 32'h4;
			int_any_enabled <= (i < 2);
			wr(4'h0, ctl);
			wr(4'h0, ctl | 32'h2);
			cyc(2);
			chk({gen_clk_en_q, periph_clk_en_q, core_clk_en_q}, 32'h0);
			cyc(30);
			chk({pll_stop_q, rtc_clk_en_q}, 32'h3);
			pll_lock <= 1'h0;
			{rtc_irq, ext_irq} <= ctl[3] ? 2'h1 : 2'h2;
			cyc(10);
			chk(pll_stop_q, 32'h1);
			{rtc_irq, ext_irq} <= ctl[3:2];
			if (i == 2)
			begin
				cyc(40);
				chk(pll_stop_q, 32'h1);
				rst <= 1'h1;
				cyc(2);
				rst <= 1'h0;
				cyc(2);
				chk({gen_clk_en_q, pll_stop_q}, 32'h2);
			end
			else
			begin
				for (n = 0; n < 200 && pll_stop_q !== 1'h0; n++)
					cyc(1);
				tmo(n);
				cyc(12);
				chk(gen_clk_en_q, 32'h0);
				pll_lock <= 1'h1;
				for (n = 0; n < 200 && gen_clk_en_q !== 1'h1; n++)
					cyc(1);
				tmo(n);
				{rtc_irq, ext_irq} <= 2'h0;
				rd(4'h0, ctl | 32'h2);
				wr(4'h0, ctl | 32'h2);
				cyc(30);
				chk({gen_clk_en_q, pll_stop_q}, 32'h2);
			end
			pll_lock <= 1'h1;
			{rtc_irq, ext_irq} <= 2'h0;
		end
		wrap_up;
	end
endmodule
